// File: flash_pin_defs.svh
//=============================================================
`ifndef FLASH_PIN_DEFS_SVH
`define FLASH_PIN_DEFS_SVH

`define OPC_BITS 8
`define ADDR_BYTES 3
`define PAGE_COUNT 4096
`define PAGE_BIN_BYTES 256
`define PAGE_STD_BYTES 264
`define PROG_CYCLES 200
`define FIFO_DEPTH 8
`define TX_FILL 8'hFF

`define OPC_PROGRAM 8'hA1
`define OPC_ERASE 8'hA2
`define OPC_RMW 8'hA3
`define OPC_PROT_MODIFY 8'hA4
`define OPC_PROT_ENABLE 8'hA5
`define OPC_LOCKDOWN 8'hA6

`endif

// File: flash_pin_pkg.sv
package flash_pin_pkg;
  typedef enum logic [3:0] {
    FR_IDLE = 4'b0001,
    FR_OPC = 4'b0010,
    FR_BODY = 4'b0100,
    FR_DROP = 4'b1000
  } frame_st_t;

  typedef enum logic [1:0] {
    OC_OTHER = 2'h0,
    OC_WRITE = 2'h1,
    OC_PROT_MOD = 2'h2,
    OC_PROT_OK = 2'h3
  } op_class_t;
endpackage

// File: pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // a change counts once the second and third stages agree
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.q;
endmodule // pin_sync
`default_nettype wire

// File: byte_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_t;

  fifo_t st_r;
  fifo_t st_nxt;
  logic [W-1:0] mem_r [D];
  logic do_wr;
  logic do_rd;

  assign in_ready_o = (st_r.cnt != D[AW:0]);
  assign out_valid_o = (st_r.cnt != '0);
  assign out_data_o = mem_r[st_r.rd];
  assign do_wr = in_valid_i && in_ready_o;
  assign do_rd = out_valid_o && out_ready_i;

  always_comb begin
    st_nxt = st_r;
    if (do_wr) begin
      st_nxt.wr = (st_r.wr == AW'(D - 1)) ? '0 : st_r.wr + 1'b1;
    end
    if (do_rd) begin
      st_nxt.rd = (st_r.rd == AW'(D - 1)) ? '0 : st_r.rd + 1'b1;
    end
    if (do_wr && !do_rd) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end else if (do_rd && !do_wr) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (do_wr) begin
      mem_r[st_r.wr] <= in_data_i;
    end
  end
endmodule // byte_fifo
`default_nettype wire

// File: flash_pin_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "flash_pin_defs.svh"
module flash_pin_if #(
  parameter int PROG_CYCLES = `PROG_CYCLES,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  input wire logic pin_rst_n_i,
  input wire logic page_bin_i,
  output logic so_o,
  output logic so_oe_n_o,
  output logic [7:0] rx_data_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_taken_o,
  output logic [7:0] opcode_o,
  output flash_pin_pkg::op_class_t op_class_o,
  output logic [23:0] addr_o,
  output logic addr_valid_o,
  output logic [11:0] page_o,
  output logic [8:0] byte_o,
  output logic busy_o,
  output logic standby_o,
  output logic hw_protect_o,
  output logic discard_o,
  output logic overrun_o
);
  import flash_pin_pkg::*;

  //=============================================================
  // state
  typedef struct packed {
    frame_st_t frame;
    logic sel;
    logic sck_q;
    logic [7:0] rx_sh;
    logic [2:0] rx_cnt;
    logic [2:0] byte_idx;
    logic [7:0] opcode;
    op_class_t oclass;
    logic [23:0] addr;
    logic addr_v;
    logic [11:0] page;
    logic [8:0] byt;
    logic [7:0] tx_sh;
    logic [2:0] tx_cnt;
    logic so;
    logic so_oe_n;
    logic tx_taken;
    logic pend_write;
    logic busy;
    logic [15:0] busy_cnt;
    logic standby;
    logic hwp;
    logic discard;
    logic overrun;
  } state_t;

  localparam state_t ST_RST = '{
    frame: FR_IDLE,
    sel: 1'b0,
    sck_q: 1'b0,
    rx_sh: 8'h00,
    rx_cnt: 3'h0,
    byte_idx: 3'h0,
    opcode: 8'h00,
    oclass: OC_OTHER,
    addr: 24'h000000,
    addr_v: 1'b0,
    page: 12'h000,
    byt: 9'h000,
    tx_sh: 8'h00,
    tx_cnt: 3'h0,
    so: 1'b0,
    so_oe_n: 1'b1,
    tx_taken: 1'b0,
    pend_write: 1'b0,
    busy: 1'b0,
    busy_cnt: 16'h0000,
    standby: 1'b1,
    hwp: 1'b0,
    discard: 1'b0,
    overrun: 1'b0
  };

  localparam logic [15:0] PROG_LAST = 16'(PROG_CYCLES - 1);

  state_t st_r;
  state_t st_nxt;

  //=============================================================
  // pin synchronisers
  logic [4:0] pin_raw;
  logic [4:0] pin_f;
  logic cs_n_f;
  logic sck_f;
  logic si_f;
  logic wp_n_f;
  logic prst_n_f;

  assign pin_raw = {pin_rst_n_i, wp_n_i, si_i, sck_i, cs_n_i};

  // wp and reset pins settle high, as the pull-up leaves them
  // serial clock settles low to match sck_q, so reset makes no false edge
  pin_sync #(
    .W(5),
    .RST_VAL(5'h19)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(pin_raw),
    .q_o(pin_f)
  );

  assign cs_n_f = pin_f[0];
  assign sck_f = pin_f[1];
  assign si_f = pin_f[2];
  assign wp_n_f = pin_f[3];
  assign prst_n_f = pin_f[4];

  //=============================================================
  // received byte buffer
  logic push;
  logic [7:0] push_data;
  logic fifo_in_ready;

  byte_fifo #(
    .W(8),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i(push_data),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .out_data_o(rx_data_o),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i)
  );

  //=============================================================
  // opcode classes
  function automatic op_class_t classify(input logic [7:0] op);
    op_class_t c;
    c = OC_OTHER;
    case (op)
      `OPC_PROGRAM, `OPC_ERASE, `OPC_RMW: c = OC_WRITE;
      `OPC_PROT_MODIFY: c = OC_PROT_MOD;
      `OPC_PROT_ENABLE, `OPC_LOCKDOWN: c = OC_PROT_OK;
      default: c = OC_OTHER;
    endcase
    return c;
  endfunction

  //=============================================================
  // next state
  logic sel_now;
  logic sck_rise;
  logic sck_fall;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  op_class_t cls;

  assign sel_now = !cs_n_f;
  assign sck_rise = sck_f && !st_r.sck_q;
  assign sck_fall = !sck_f && st_r.sck_q;
  assign rx_byte = {st_r.rx_sh[6:0], si_f};
  assign tx_byte = tx_valid_i ? tx_data_i : `TX_FILL;
  assign cls = classify(rx_byte);
  assign push_data = rx_byte;

  always_comb begin
    st_nxt = st_r;
    push = 1'b0;
    st_nxt.sck_q = sck_f;
    st_nxt.sel = sel_now;
    st_nxt.tx_taken = 1'b0;
    st_nxt.discard = 1'b0;
    st_nxt.hwp = !wp_n_f;
    if (st_r.busy) begin
      // self-timed countdown, no serial clock needed
      if (st_r.busy_cnt == 16'h0000) begin
        st_nxt.busy = 1'b0;
      end else begin
        st_nxt.busy_cnt = st_r.busy_cnt - 16'h0001;
      end
    end
    if (!st_r.sel && sel_now) begin
      // select fall opens a frame
      st_nxt.frame = FR_OPC;
      st_nxt.rx_cnt = 3'h0;
      st_nxt.byte_idx = 3'h0;
      st_nxt.tx_cnt = 3'h0;
      st_nxt.addr_v = 1'b0;
      st_nxt.pend_write = 1'b0;
      st_nxt.overrun = 1'b0;
    end else if (st_r.sel && !sel_now) begin
      // select rise closes it; dropped frames return to idle
      st_nxt.frame = FR_IDLE;
      if (st_r.pend_write && !st_r.busy) begin
        st_nxt.busy = 1'b1;
        st_nxt.busy_cnt = PROG_LAST;
      end
    end else if (st_r.sel && sck_rise && (st_r.frame == FR_OPC || st_r.frame == FR_BODY)) begin
      // sample input on rising edge, only while selected
      st_nxt.rx_sh = rx_byte;
      st_nxt.rx_cnt = st_r.rx_cnt + 3'h1;
      if (st_r.rx_cnt == 3'h7) begin
        if (st_r.frame == FR_OPC) begin
          // first byte is the opcode
          if ((cls == OC_WRITE || cls == OC_PROT_MOD) && st_r.hwp) begin
            st_nxt.frame = FR_DROP;
            st_nxt.discard = 1'b1;
          end else begin
            // enable and lockdown pass even when protected
            push = 1'b1;
            st_nxt.frame = FR_BODY;
            st_nxt.opcode = rx_byte;
            st_nxt.oclass = cls;
            // read-modify-write runs as a buffered self-timed write
            st_nxt.pend_write = (cls == OC_WRITE) || (cls == OC_PROT_MOD);
          end
        end else begin
          // data flows into the buffer even while a page programs
          push = 1'b1;
          if (st_r.byte_idx < 3'(`ADDR_BYTES)) begin
            st_nxt.addr = {st_r.addr[15:0], rx_byte};
            st_nxt.byte_idx = st_r.byte_idx + 3'h1;
            if (st_r.byte_idx == 3'(`ADDR_BYTES - 1)) begin
              st_nxt.addr_v = 1'b1;
              // dummy bits dropped by page size
              if (page_bin_i) begin
                st_nxt.page = st_nxt.addr[19:8];
                st_nxt.byt = {1'b0, st_nxt.addr[7:0]};
              end else begin
                st_nxt.page = st_nxt.addr[20:9];
                st_nxt.byt = st_nxt.addr[8:0];
              end
            end
          end
        end
      end
    end
    if (push && !fifo_in_ready) begin
      st_nxt.overrun = 1'b1;
    end
    if (st_r.sel && sel_now && sck_fall) begin
      // output changes on falling edge, msb first
      if (st_r.tx_cnt == 3'h0) begin
        st_nxt.so = tx_byte[7];
        st_nxt.tx_sh = {tx_byte[6:0], 1'b0};
        st_nxt.tx_taken = tx_valid_i;
      end else begin
        st_nxt.so = st_r.tx_sh[7];
        st_nxt.tx_sh = {st_r.tx_sh[6:0], 1'b0};
      end
      st_nxt.tx_cnt = st_r.tx_cnt + 3'h1;
    end
    st_nxt.so_oe_n = !sel_now;
    if (!prst_n_f) begin
      // reset pin aborts and holds idle while low
      st_nxt = ST_RST;
      st_nxt.sck_q = sck_f;
      st_nxt.sel = sel_now;
      st_nxt.hwp = !wp_n_f;
      push = 1'b0;
    end
    st_nxt.standby = !sel_now && !st_nxt.busy;
  end

  // power-on reset comes in on rst_n_i
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  //=============================================================
  // outputs
  assign so_o = st_r.so;
  assign so_oe_n_o = st_r.so_oe_n;
  assign tx_taken_o = st_r.tx_taken;
  assign opcode_o = st_r.opcode;
  assign op_class_o = st_r.oclass;
  assign addr_o = st_r.addr;
  assign addr_valid_o = st_r.addr_v;
  assign page_o = st_r.page;
  assign byte_o = st_r.byt;
  assign busy_o = st_r.busy;
  assign standby_o = st_r.standby;
  assign hw_protect_o = st_r.hwp;
  assign discard_o = st_r.discard;
  assign overrun_o = st_r.overrun;

  //=============================================================
  // assertions
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_so_hiz_desel: assert property (!st_r.sel |-> so_oe_n_o)
    else $error("serial output driven while deselected");

  a_no_push_desel: assert property (!st_r.sel |-> !push)
    else $error("byte accepted while deselected");

  a_push_on_rise: assert property (push |-> sck_rise && st_r.rx_cnt == 3'h7)
    else $error("byte completed off a rising edge");

  a_so_on_fall: assert property (st_r.sel && $past(prst_n_f) && $changed(so_o) |-> $past(sck_fall))
    else $error("serial output moved off a falling edge");

  a_drop_no_push: assert property (st_r.frame == FR_DROP |-> !push)
    else $error("dropped command still pushed data");

  a_wp_discards: assert property (
    st_r.frame == FR_OPC && sck_rise && st_r.rx_cnt == 3'h7 && st_r.hwp && !st_r.busy
    && cls == OC_WRITE && prst_n_f && st_r.sel && sel_now
    |=> discard_o && !busy_o ##1 !busy_o)
    else $error("protected write not discarded");

  a_busy_no_standby: assert property (busy_o |-> !standby_o)
    else $error("standby during self-timed cycle");

  a_busy_end: assert property (busy_o && st_r.busy_cnt == 16'h0000 && prst_n_f |=> !busy_o)
    else $error("self-timed cycle overran its count");

  a_pin_reset_idle: assert property (!prst_n_f |=> !busy_o && st_r.frame == FR_IDLE)
    else $error("reset pin did not force idle");

  a_start_busy: assert property (
    st_r.sel && !sel_now && st_r.pend_write && !st_r.busy && prst_n_f
    |=> busy_o && st_r.busy_cnt == PROG_LAST)
    else $error("self-timed cycle did not start at select rise");
endmodule // flash_pin_if
`default_nettype wire

// File: host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic sys_clk_i,
  input wire logic so_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o
);
  // ==========================================
  // idle levels: clock parked low outside frames
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  // data line churns while deselected so stale bits never look valid
  always @(posedge sys_clk_i) begin
    if (cs_n_o) begin
      si_o <= ~si_o;
    end
  end
  // ==========================================
  // frame edges
  task automatic frame_start;
    @(posedge sys_clk_i);
    cs_n_o <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic frame_end;
    repeat (4) @(posedge sys_clk_i);
    cs_n_o <= 1'b1;
  endtask
  // one byte, msb first, 320 ns clock; output sampled late in the high
  // phase because the synchronised device lags its falling edge
  task automatic xfer_byte(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      @(posedge sys_clk_i);
      si_o <= d[i];
      repeat (3) @(posedge sys_clk_i);
      sck_o <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      q[i] = so_i;
      @(posedge sys_clk_i);
      sck_o <= 1'b0;
    end
  endtask
endmodule // host_model
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "flash_pin_defs.svh"
module tb_top;
  import flash_pin_pkg::*;
  typedef struct packed {
    logic wp_n;
    logic [7:0] opc;
    logic [1:0] cls;
    logic disc;
  } row_t;
  localparam logic [23:0] ADDR = 24'h0AB3C5;
  logic sys_clk_i, rst_n_i = 1'b0, wp_n_i = 1'b1, pin_rst_n_i = 1'b1, page_bin_i = 1'b1;
  logic rx_ready_i = 1'b1, tx_valid_i = 1'b0;
  logic [7:0] tx_data_i = 8'h00;
  logic cs_n, sck, si, so_o, so_oe_n_o, rx_valid_o, tx_taken_o, addr_valid_o;
  logic busy_o, standby_o, hw_protect_o, discard_o, overrun_o, so_line, saw_discard;
  logic [7:0] rx_data_o, opcode_o, q0, q1;
  op_class_t op_class_o;
  logic [23:0] addr_o;
  logic [11:0] page_o;
  logic [8:0] byte_o;
  logic [7:0] got_q[$];
  int failures = 0, tests_run = 0, taken_cnt = 0;
  row_t rows[10] = '{'{1'b1, `OPC_PROGRAM, 2'h1, 1'b0}, '{1'b0, `OPC_PROGRAM, 2'h1, 1'b1},
    '{1'b1, `OPC_ERASE, 2'h1, 1'b0}, '{1'b0, `OPC_ERASE, 2'h1, 1'b1}, '{1'b1, `OPC_RMW, 2'h1, 1'b0},
    '{1'b0, `OPC_RMW, 2'h1, 1'b1}, '{1'b1, `OPC_PROT_MODIFY, 2'h2, 1'b0},
    '{1'b0, `OPC_PROT_MODIFY, 2'h2, 1'b1}, '{1'b0, `OPC_PROT_ENABLE, 2'h3, 1'b0},
    '{1'b0, `OPC_LOCKDOWN, 2'h3, 1'b0}};
  // released output reads as the inverse of its last level
  assign so_line = so_oe_n_o ? ~so_o : so_o;
  // ==========================================
  // clock, design and far side
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  flash_pin_if #(.PROG_CYCLES(10), .FIFO_DEPTH(8)) u_flash_pin_if (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .wp_n_i(wp_n_i), .pin_rst_n_i(pin_rst_n_i),
    .page_bin_i(page_bin_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o), .rx_data_o(rx_data_o),
    .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i),
    .tx_taken_o(tx_taken_o), .opcode_o(opcode_o), .op_class_o(op_class_o), .addr_o(addr_o),
    .addr_valid_o(addr_valid_o), .page_o(page_o), .byte_o(byte_o), .busy_o(busy_o), .standby_o(standby_o),
    .hw_protect_o(hw_protect_o), .discard_o(discard_o), .overrun_o(overrun_o));
  host_model u_host_model (.sys_clk_i(sys_clk_i), .so_i(so_line), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
  always @(posedge sys_clk_i) begin
    if (rx_valid_o === 1'b1 && rx_ready_i) got_q.push_back(rx_data_o);
    if (discard_o === 1'b1) saw_discard = 1'b1;
    if (tx_taken_o === 1'b1) taken_cnt++;
  end
  // ==========================================
  // checking and ending
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic run_frame(input logic [7:0] opc);
    u_host_model.frame_start();
    u_host_model.xfer_byte(opc, q0);
    for (int i = 2; i >= 0; i--) u_host_model.xfer_byte(ADDR[i*8+:8], q0);
    u_host_model.frame_end();
    repeat (8) @(posedge sys_clk_i);
  endtask
  initial begin
    repeat (40000) @(posedge sys_clk_i);
    failures++;
    tally_and_finish();
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (16) @(posedge sys_clk_i);
    check({so_oe_n_o, standby_o, busy_o, rx_valid_o}, 4'b1100);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    foreach (rows[k]) begin
      wp_n_i <= rows[k].wp_n;
      repeat (8) @(posedge sys_clk_i);
      got_q.delete();
      saw_discard = 1'b0;
      check(hw_protect_o, !rows[k].wp_n);
      run_frame(rows[k].opc);
      check(saw_discard, rows[k].disc);
      check(got_q.size(), rows[k].disc ? 0 : 4);
      if (!rows[k].disc) begin
        check({got_q[0], got_q[1], got_q[2], got_q[3]}, {rows[k].opc, ADDR});
        check(op_class_o, rows[k].cls);
        check(opcode_o, rows[k].opc);
        check({addr_valid_o, addr_o}, {1'b1, ADDR});
      end
      check({busy_o, standby_o}, (!rows[k].disc && rows[k].cls inside {2'h1, 2'h2}) ? 2'b10 : 2'b01);
      repeat (20) @(posedge sys_clk_i);
      check({busy_o, standby_o}, 2'b01);
    end
    wp_n_i <= 1'b1;
    for (int pb = 0; pb < 2; pb++) begin
      page_bin_i <= pb[0];
      run_frame(8'h3C);
      if (pb == 1) check({page_o, byte_o}, {ADDR[19:8], 1'b0, ADDR[7:0]});
      else check({page_o, byte_o}, {ADDR[20:9], ADDR[8:0]});
    end
    // consumer stalls while ten bytes arrive into eight places
    rx_ready_i <= 1'b0;
    got_q.delete();
    u_host_model.frame_start();
    for (int i = 0; i < 10; i++) u_host_model.xfer_byte(8'h3C + i[7:0], q0);
    u_host_model.frame_end();
    repeat (8) @(posedge sys_clk_i);
    check({overrun_o, rx_valid_o}, 2'b11);
    rx_ready_i <= 1'b1;
    repeat (12) @(posedge sys_clk_i);
    check(got_q.size(), 8);
    check({got_q[0], got_q[7], rx_valid_o}, {8'h3C, 8'h43, 1'b0});
    // outgoing byte, loaded on the first falling edge
    tx_data_i <= 8'h5A;
    tx_valid_i <= 1'b1;
    u_host_model.frame_start();
    repeat (2) @(posedge sys_clk_i);
    check(so_oe_n_o, 1'b0);
    u_host_model.xfer_byte(8'h3C, q0);
    u_host_model.xfer_byte(8'h00, q1);
    check({q0[6:0], q1[7]}, 8'h5A);
    check(taken_cnt > 0, 1'b1);
    u_host_model.frame_end();
    tx_valid_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    check(so_oe_n_o, 1'b1);
    // pin reset in the middle of a program frame
    u_host_model.frame_start();
    u_host_model.xfer_byte(`OPC_PROGRAM, q0);
    u_host_model.xfer_byte(8'h00, q0);
    pin_rst_n_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    check({busy_o, so_oe_n_o, addr_valid_o}, 3'b010);
    pin_rst_n_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    u_host_model.xfer_byte(8'h00, q0);
    u_host_model.xfer_byte(8'h00, q0);
    u_host_model.frame_end();
    repeat (8) @(posedge sys_clk_i);
    check({busy_o, addr_valid_o}, 2'b00);
    run_frame(`OPC_PROGRAM);
    check(busy_o, 1'b1);
    repeat (20) @(posedge sys_clk_i);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
